// *** hw/eeprom_wr_pkg.sv ***
`default_nettype none
package eeprom_wr_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int          CLK_MHZ     = 100;        // System clock rate
	// ----------------------------------------
	// Select decoding
	// ----------------------------------------
	localparam logic [6:0]  SEL_CODE    = 7'h3C;      // Arbitrary select pattern
	// ----------------------------------------
	// Bit and byte counting
	// ----------------------------------------
	localparam logic [3:0]  BIT_ZERO    = 4'h0;       // First bit of a byte
	localparam logic [3:0]  BIT_ONE     = 4'h1;       // Count after the first bit
	localparam logic [3:0]  BIT_LAST    = 4'h7;       // Eighth data bit
	localparam logic [3:0]  BIT_ACK     = 4'h8;       // Ninth, acknowledge bit
	localparam logic [1:0]  DCNT_ZERO   = 2'h0;       // No data byte yet
	localparam logic [1:0]  DCNT_ONE    = 2'h1;       // Exactly one data byte
	localparam logic [1:0]  DCNT_MANY   = 2'h2;       // More than one (saturates)
	// ----------------------------------------
	// Address layout
	// ----------------------------------------
	localparam int          REG_BIT     = 15;         // Register space select
	localparam int          ARR_MSB     = 11;         // Array index top bit
	localparam int          ARR_NXT     = 10;         // Second array bit
	localparam int          PAGE_LSB    = 5;          // Page number low bit
	localparam int          OFS_MSB     = 4;          // In-page offset top bit
	localparam logic [4:0]  OFS_ONE     = 5'h01;      // Offset step
	localparam logic [4:0]  OFS_LAST    = 5'h1F;      // Last entry of a page
	localparam int          PAGE_BYTES  = 32;         // Bytes per page
	// ----------------------------------------
	// Protection register fields
	// ----------------------------------------
	localparam logic [3:0]  WP_RESET    = 4'h0;       // Everything writable
	localparam int          WP_EN       = 3;          // Protection enable
	localparam int          WP_SZ_HI    = 2;          // Region size high
	localparam int          WP_SZ_LO    = 1;          // Region size low
	localparam int          WP_LOCK     = 0;          // Freezes the register
	localparam logic [1:0]  SZ_QTR      = 2'b00;      // Upper quarter
	localparam logic [1:0]  SZ_HALF     = 2'b01;      // Upper half
	localparam logic [1:0]  SZ_3QTR     = 2'b10;      // Upper three quarters
	localparam logic [1:0]  A_TOPQ      = 2'b11;      // Top quarter of the array
	localparam logic [1:0]  A_BOTQ      = 2'b00;      // Bottom quarter
	localparam logic [3:0]  RD_PAD      = 4'h0;       // Upper read-back bits
	// ----------------------------------------
	// State types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,                             // Standby, detached
		ST_SEL  = 3'b001,                             // Select byte
		ST_AHI  = 3'b010,                             // High address byte
		ST_ALO  = 3'b011,                             // Low address byte
		ST_DATA = 3'b100                              // Data bytes
	} link_st_e;
	typedef enum logic [1:0] {
		P_IDLE  = 2'b00,                              // No write cycle
		P_WRITE = 2'b01,                              // Copying page latches
		P_WAIT  = 2'b10                               // Program time running
	} prog_st_e;
	typedef struct packed {
		logic        we;                              // Write strobe
		logic [11:0] addr;                            // Array byte index
		logic [7:0]  data;                            // Byte to store
	} mem_wr_s;
endpackage
`default_nettype wire

// *** hw/eeprom_wr_path.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_wr_path
	import eeprom_wr_pkg::*;
#(
	parameter int PROG_TIME_US = 1000                 // Internal program time
) (
	input  wire logic        clock_i,                 // System clock
	input  wire logic        rst_n_i,                 // Synchronous reset
	input  wire logic        scl_i,                   // Serial clock, link domain
	input  wire logic        sda_i,                   // Serial data level
	output logic             sda_o,                   // Data drive value
	output logic             sda_oe_n_o,              // Low while pulling data
	output logic             busy_o,                  // Write cycle running
	output mem_wr_s          mem_wr_o,                // Array write port
	output logic [11:0]      cur_addr_o,              // Shared address counter
	output logic [7:0]       wp_rd_data_o,            // Protection read-back
	output logic             wp_rd_ok_o               // Read-back allowed
);
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic              start_tgl_r, stop_tgl_r;       // Condition toggles
	logic              start_ack_r, stop_ack_r;       // Seen copies
	logic              rst_s1_r, rst_s2_r;            // Reset into link domain
	logic              busy_s1_r, busy_s2_r;          // Busy into link domain
	logic [3:0]        wp_s1_r, wp_s2_r;              // Protection into link
	link_st_e          st_r;                          // Link state
	logic [3:0]        cnt_r;                         // Bit counter
	logic [7:0]        shift_r;                       // Receive shift
	logic              ack_r;                         // Answer for this byte
	logic [15:0]       addr_r;                        // Write address
	logic [1:0]        dcnt_r;                        // Data bytes seen
	logic [7:0]        reg_byte_r;                    // First register byte
	logic [7:0]        buf_r [PAGE_BYTES];            // Page latches
	logic [31:0]       mask_r;                        // Latch valid bits
	logic              armed_r;                       // In slot after data ack
	logic              stp_q1_r, stp_q2_r, stp_q3_r;  // Stop into system
	logic              arm_q1_r, arm_q2_r;            // Armed into system
	prog_st_e          pst_r;                         // Write cycle state
	logic [4:0]        idx_r;                         // Latch walk index
	logic [31:0]       tcnt_r;                        // Program timer
	logic              busy_r;                        // Write cycle flag
	logic [3:0]        wp_r;                          // Protection register
	logic              new_start, new_stop, normal;
	logic              byte_done, ack_edge, stop_evt, trig;
	logic [7:0]        byte_w;

	// Region test on the top two array bits
	function automatic logic prot_f(input logic [3:0] wp, input logic [11:0] a);
		logic [1:0] q;
		q = a[ARR_MSB:ARR_NXT];
		case (wp[WP_SZ_HI:WP_SZ_LO])
			SZ_QTR:  prot_f = (q == A_TOPQ);
			SZ_HALF: prot_f = a[ARR_MSB];
			SZ_3QTR: prot_f = (q != A_BOTQ);
			default: prot_f = 1'b1;
		endcase
		prot_f = prot_f & wp[WP_EN];
	endfunction

	// ----------------------------------------
	// Start and Stop detection
	// ----------------------------------------
	// Data line used as a clock: conditions arrive while the serial clock is still
	always_ff @(negedge sda_i) begin
		if (!rst_n_i) begin
			start_tgl_r <= 1'b0;
		end else if (scl_i) begin
			start_tgl_r <= ~start_tgl_r;
		end
	end

	// Stop edge toggle
	always_ff @(posedge sda_i) begin
		if (!rst_n_i) begin
			stop_tgl_r <= 1'b0;
		end else if (scl_i) begin
			stop_tgl_r <= ~stop_tgl_r;
		end
	end

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	// Level synchronisers; inputs are quasi-static across frames
	always_ff @(posedge scl_i) begin
		rst_s1_r  <= rst_n_i;
		rst_s2_r  <= rst_s1_r;
		busy_s1_r <= busy_r;
		busy_s2_r <= busy_s1_r;
		wp_s1_r   <= wp_r;
		wp_s2_r   <= wp_s1_r;
	end

	// Toggles hold still for a whole clock low, so one compare suffices
	assign new_start = (start_tgl_r != start_ack_r);
	assign new_stop  = (stop_tgl_r != stop_ack_r);
	assign normal    = rst_s2_r & ~new_start & ~new_stop & ~busy_s2_r;
	assign byte_w    = {shift_r[6:0], sda_i};
	assign byte_done = normal & (st_r != ST_IDLE) & (cnt_r == BIT_LAST);
	assign ack_edge  = normal & (st_r != ST_IDLE) & (cnt_r == BIT_ACK);

	// Condition bookkeeping
	always_ff @(posedge scl_i) begin
		if (!rst_s2_r) begin
			start_ack_r <= 1'b0;
			stop_ack_r  <= 1'b0;
		end else begin
			start_ack_r <= start_tgl_r;
			stop_ack_r  <= stop_tgl_r;
		end
	end

	// Bit framing and byte answers
	always_ff @(posedge scl_i) begin
		if (!rst_s2_r) begin
			st_r    <= ST_IDLE;
			cnt_r   <= BIT_ZERO;
			shift_r <= 8'h00;
			ack_r   <= 1'b0;
		end else if (new_start && !busy_s2_r) begin
			// First bit rides on the first rising edge of the frame
			st_r    <= ST_SEL;
			cnt_r   <= BIT_ONE;
			shift_r <= {7'h00, sda_i};
			ack_r   <= 1'b0;
		end else if (!normal) begin
			// Stop, or any edge while busy: back to standby
			st_r    <= ST_IDLE;
			cnt_r   <= BIT_ZERO;
			ack_r   <= 1'b0;
		end else if (st_r != ST_IDLE) begin
			if (cnt_r == BIT_ACK) begin
				cnt_r <= BIT_ZERO;
				ack_r <= 1'b0;
				case (st_r)
					ST_SEL:  st_r <= (!ack_r || shift_r[0]) ? ST_IDLE : ST_AHI;
					ST_AHI:  st_r <= ST_ALO;
					ST_ALO:  st_r <= ST_DATA;
					default: st_r <= st_r;
				endcase
			end else begin
				shift_r <= byte_w;
				cnt_r   <= cnt_r + BIT_ONE;
				if (cnt_r == BIT_LAST) begin
					case (st_r)
						ST_SEL:  ack_r <= (byte_w[7:1] == SEL_CODE);
						ST_DATA: ack_r <= addr_r[REG_BIT] |
							~prot_f(wp_s2_r, addr_r[ARR_MSB:0]);
						default: ack_r <= 1'b1;
					endcase
				end
			end
		end
	end

	// Address bytes and data byte counting
	always_ff @(posedge scl_i) begin
		if (!rst_s2_r) begin
			addr_r     <= 16'h0000;
			dcnt_r     <= DCNT_ZERO;
			reg_byte_r <= 8'h00;
		end else if (ack_edge) begin
			case (st_r)
				ST_AHI: addr_r[15:8] <= shift_r;
				ST_ALO: begin
					addr_r[7:0] <= shift_r;
					dcnt_r      <= DCNT_ZERO;
				end
				ST_DATA: begin
					if (dcnt_r == DCNT_ZERO) begin
						reg_byte_r <= shift_r;
					end
					if (dcnt_r != DCNT_MANY) begin
						dcnt_r <= dcnt_r + DCNT_ONE;
					end
					if (!addr_r[REG_BIT]) begin
						// Offset wraps, page bits stay
						addr_r[OFS_MSB:0] <= addr_r[OFS_MSB:0] + OFS_ONE;
					end
				end
				default: addr_r <= addr_r;
			endcase
		end
	end

	// Page latches, one per in-page offset
	genvar gi;
	generate
		for (gi = 0; gi < PAGE_BYTES; gi++) begin : g_latch
			always_ff @(posedge scl_i) begin
				if (!rst_s2_r) begin
					buf_r[gi]  <= 8'h00;
					mask_r[gi] <= 1'b0;
				end else if (ack_edge && st_r == ST_ALO) begin
					mask_r[gi] <= 1'b0;
				end else if (ack_edge && st_r == ST_DATA && ack_r && !addr_r[REG_BIT]
						&& addr_r[OFS_MSB:0] == 5'(gi)) begin
					buf_r[gi]  <= shift_r;
					mask_r[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	// Set by the rise that opens the slot after a data byte's acknowledge; a Stop
	// needs that rise first, so arming on the ninth rise would always be too early
	always_ff @(posedge scl_i) begin
		if (!rst_s2_r) begin
			armed_r <= 1'b0;
		end else begin
			armed_r <= normal & (st_r == ST_DATA) & (cnt_r == BIT_ZERO)
				& (dcnt_r != DCNT_ZERO);
		end
	end

	// Acknowledge drive changes only while the clock is low
	always_ff @(negedge scl_i) begin
		if (!rst_s2_r) begin
			sda_oe_n_o <= 1'b1;
			sda_o      <= 1'b0;
		end else begin
			sda_oe_n_o <= ~((cnt_r == BIT_ACK) & ack_r & ~busy_s2_r);
			sda_o      <= 1'b0;
		end
	end

	// ----------------------------------------
	// System domain
	// ----------------------------------------
	// Stop event and armed level enter with equal latency
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			stp_q1_r <= 1'b0;
			stp_q2_r <= 1'b0;
			stp_q3_r <= 1'b0;
			arm_q1_r <= 1'b0;
			arm_q2_r <= 1'b0;
		end else begin
			stp_q1_r <= stop_tgl_r;
			stp_q2_r <= stp_q1_r;
			stp_q3_r <= stp_q2_r;
			arm_q1_r <= armed_r;
			arm_q2_r <= arm_q1_r;
		end
	end

	assign stop_evt = stp_q2_r ^ stp_q3_r;
	assign trig     = stop_evt & arm_q2_r & (pst_r == P_IDLE);

	// Write cycle; latches and address hold still while busy
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pst_r      <= P_IDLE;
			idx_r      <= 5'h00;
			tcnt_r     <= 32'h0000_0000;
			busy_r     <= 1'b0;
			mem_wr_o   <= '0;
			cur_addr_o <= 12'h000;
		end else begin
			mem_wr_o.we <= 1'b0;
			case (pst_r)
				P_IDLE: begin
					if (trig) begin
						busy_r <= 1'b1;
						idx_r  <= 5'h00;
						tcnt_r <= 32'h0000_0000;
						pst_r  <= addr_r[REG_BIT] ? P_WAIT : P_WRITE;
					end
				end
				P_WRITE: begin
					mem_wr_o.we   <= mask_r[idx_r];
					mem_wr_o.addr <= {addr_r[ARR_MSB:PAGE_LSB], idx_r};
					mem_wr_o.data <= buf_r[idx_r];
					idx_r         <= idx_r + OFS_ONE;
					if (idx_r == OFS_LAST) begin
						pst_r <= P_WAIT;
					end
				end
				P_WAIT: begin
					tcnt_r <= tcnt_r + 32'h0000_0001;
					if (tcnt_r == PROG_CYCLES[31:0] - 32'h0000_0001) begin
						pst_r  <= P_IDLE;
						busy_r <= 1'b0;
						if (!addr_r[REG_BIT]) begin
							cur_addr_o <= addr_r[ARR_MSB:0];
						end
					end
				end
				default: pst_r <= P_IDLE;
			endcase
		end
	end

	// Protection register update at write cycle start
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wp_r <= WP_RESET;
		end else if (trig && addr_r[REG_BIT] && dcnt_r == DCNT_ONE
				&& !wp_r[WP_LOCK]) begin
			wp_r <= reg_byte_r[3:0];
		end
	end

	// Read-back for the read path
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wp_rd_data_o <= 8'h00;
			wp_rd_ok_o   <= 1'b0;
		end else begin
			wp_rd_data_o <= {RD_PAD, wp_r};
			wp_rd_ok_o   <= ~busy_r;
		end
	end

	assign busy_o = busy_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sel_match: assert property (@(posedge scl_i) disable iff (!rst_s2_r)
		byte_done && st_r == ST_SEL && byte_w[7:1] == SEL_CODE |=> ack_r && cnt_r == BIT_ACK)
		else $error("matching select not answered");
	a_sel_drop: assert property (@(posedge scl_i) disable iff (!rst_s2_r)
		ack_edge && st_r == ST_SEL && !ack_r |=> st_r == ST_IDLE)
		else $error("unmatched select kept the bus");
	a_busy_deaf: assert property (@(posedge scl_i) disable iff (!rst_s2_r)
		busy_s2_r |=> st_r == ST_IDLE && !ack_r)
		else $error("request taken while busy");
	a_prot_nak: assert property (@(posedge scl_i) disable iff (!rst_s2_r)
		byte_done && st_r == ST_DATA && !addr_r[REG_BIT]
		&& prot_f(wp_s2_r, addr_r[ARR_MSB:0]) |=> !ack_r)
		else $error("protected byte acknowledged");
	a_page_wrap: assert property (@(posedge scl_i) disable iff (!rst_s2_r)
		ack_edge && st_r == ST_DATA && !addr_r[REG_BIT] |=>
		addr_r[15:PAGE_LSB] == $past(addr_r[15:PAGE_LSB])
		&& addr_r[OFS_MSB:0] == $past(addr_r[OFS_MSB:0]) + OFS_ONE)
		else $error("page offset step wrong");
	a_ack_slot: assert property (@(negedge scl_i) disable iff (!rst_s2_r)
		!sda_oe_n_o |-> $past(cnt_r) == BIT_ACK && $past(ack_r))
		else $error("data pulled outside ninth bit");
	a_prog_start: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		trig |=> busy_r ##1 busy_r)
		else $error("write cycle not started");
	a_prog_skip: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		stop_evt && !arm_q2_r && !busy_r |=> !busy_r)
		else $error("write cycle on wrong Stop");
	a_lock_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wp_r[WP_LOCK] |=> $stable(wp_r))
		else $error("locked register changed");
	a_multi_drop: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		trig && addr_r[REG_BIT] && dcnt_r != DCNT_ONE |=> $stable(wp_r))
		else $error("multi-byte register write kept");
	a_rd_block: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		busy_r |=> !wp_rd_ok_o)
		else $error("register readable while busy");
	a_addr_next: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$fell(busy_r) && !addr_r[REG_BIT] |-> cur_addr_o == addr_r[ARR_MSB:0])
		else $error("address counter not updated");

	c_prog: cover property (@(posedge clock_i) disable iff (!rst_n_i) trig);
	c_reg_wr: cover property (@(posedge clock_i) disable iff (!rst_n_i) $changed(wp_r));
	c_sel_nak: cover property (@(posedge scl_i) disable iff (!rst_s2_r)
		ack_edge && st_r == ST_SEL && !ack_r);
	c_page_wrap: cover property (@(posedge scl_i) disable iff (!rst_s2_r)
		ack_edge && st_r == ST_DATA && addr_r[OFS_MSB:0] == OFS_LAST);
endmodule // eeprom_wr_path
`default_nettype wire

// *** tb/i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Serial bus master, 15 ns bit time
// ----------------------------------------
module i2c_master_model (
	input  wire logic sda_i,                  // Resolved data wire
	output var logic  scl_o,                  // Clock, still between frames
	output var logic  sda_o                   // Data drive, 1 releases
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// Start, also used as repeated Start from clock low
	task automatic start();
		sda_o = 1'b1;
		#3.5 scl_o = 1'b1;
		#4 sda_o = 1'b0;
		#4 scl_o = 1'b0;
		#3.5;
	endtask
	// Stop ends the talk and parks the bus high
	task automatic stop();
		sda_o = 1'b0;
		#3.5 scl_o = 1'b1;
		#4 sda_o = 1'b1;
		#7.5;
	endtask
	// One bit, data moved only with clock low
	task automatic clk_bit(input logic b, output logic seen);
		sda_o = b;
		#3.5 scl_o = 1'b1;
		#4 seen = sda_i;
		#3.5 scl_o = 1'b0;
		#4;
	endtask
	// Byte out, MSB first, then line released for the answer
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic seen;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], seen);
		end
		clk_bit(1'b1, seen);
		ack = ~seen;
	endtask
	// Idle pulses, data held where it is
	task automatic pulses(input int n);
		logic seen;
		for (int i = 0; i < n; i++) begin
			clk_bit(sda_o, seen);
		end
	endtask
endmodule // i2c_master_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench
	import eeprom_wr_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clock_i;                     // System clock
	logic        rst_n_i;                     // Synchronous reset
	logic        scl;                         // Serial clock
	logic        sda_m;                       // Master drive
	logic        sda_line;                    // Wire level, pulled up
	logic        sda_o;                       // Device drive value
	logic        sda_oe_n_o;                  // Device pull enable
	logic        busy_o;                      // Write cycle running
	logic        wp_rd_ok_o;                  // Read-back allowed
	mem_wr_s     mem_wr_o;                    // Array write port
	logic [11:0] cur_addr_o;                  // Address counter
	logic [7:0]  wp_rd_data_o;                // Protection read-back
	int          n_fail;                      // Mismatches
	int          n_tests;                     // Comparisons
	logic [19:0] wq[$];                       // Array writes seen
	assign sda_line = sda_m & (sda_oe_n_o | sda_o);
	eeprom_wr_path #(.PROG_TIME_US(1)) dut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .busy_o(busy_o), .mem_wr_o(mem_wr_o), .cur_addr_o(cur_addr_o),
		.wp_rd_data_o(wp_rd_data_o), .wp_rd_ok_o(wp_rd_ok_o));
	i2c_master_model mst (.sda_i(sda_line), .scl_o(scl), .sda_o(sda_m));
	// ----------------------------------------
	// Clock, write monitor, checking
	// ----------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		if (mem_wr_o.we === 1'b1) wq.push_back({mem_wr_o.addr, mem_wr_o.data});
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Write frame: n data bytes d0, d0+1.. then Stop
	task automatic wr(input logic [15:0] a, input logic [7:0] d0, input int n, output logic [7:0] acks);
		logic ak;
		acks = 8'h00;
		wq.delete();
		mst.start();
		mst.send_byte({SEL_CODE, 1'b0}, ak);
		acks[0] = ak;
		mst.send_byte(a[15:8], ak);
		acks[1] = ak;
		mst.send_byte(a[7:0], ak);
		acks[2] = ak;
		for (int i = 0; i < n; i++) begin
			mst.send_byte(d0 + 8'(i), ak);
			acks[3+i] = ak;
		end
		mst.stop();
	endtask
	// Poll with select until answered; busy refusals must show
	task automatic poll();
		logic ak;
		int   nr;
		nr = 0;
		repeat (10) @(negedge clock_i);
		do begin
			mst.start();
			mst.send_byte({SEL_CODE, 1'b0}, ak);
			if (ak !== 1'b1) nr++;
			if (nr == 1) chk(wp_rd_ok_o, 1'b0);
		end while (ak !== 1'b1 && nr < 200);
		chk(ak, 1'b1);
		mst.stop();
		repeat (3) @(negedge clock_i);
		chk(nr > 0, 1'b1);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_byte();
		logic [7:0] ak;
		wr(16'h7123, 8'hA5, 1, ak);
		chk(ak, 8'h0F);
		poll();
		chk(32'(wq.size()), 1);
		chk(wq[0], {12'h123, 8'hA5});
		chk(cur_addr_o, 12'h124);
	endtask
	task automatic s_select();
		logic ak;
		mst.start();
		mst.send_byte({SEL_CODE ^ 7'h01, 1'b0}, ak);
		chk(ak, 1'b0);
		mst.send_byte({SEL_CODE, 1'b0}, ak);
		chk(ak, 1'b0);
		mst.start();
		mst.send_byte({SEL_CODE, 1'b1}, ak);
		chk(ak, 1'b1);
		mst.start();
		mst.send_byte({SEL_CODE, 1'b0}, ak);
		mst.send_byte(8'h00, ak);
		mst.stop();
		repeat (10) @(negedge clock_i);
		chk(busy_o, 1'b0);
	endtask
	task automatic s_page();
		logic [7:0] ak;
		wr(16'h001E, 8'h10, 3, ak);
		chk(ak, 8'h3F);
		poll();
		chk(32'(wq.size()), 3);
		chk(wq[0], {12'h000, 8'h12});
		chk(wq[2], {12'h01F, 8'h11});
		chk(cur_addr_o, 12'h001);
	endtask
	task automatic s_protect();
		logic [7:0]  ak;
		logic [11:0] bnd[4] = '{12'hC00, 12'h800, 12'h400, 12'h000};
		for (int s = 0; s < 4; s++) begin
			wr(16'h8000, 8'hF8 | 8'(s << 1), 1, ak);
			poll();
			chk(wp_rd_data_o, 8'h08 | 8'(s << 1));
			wr({4'h0, bnd[s]}, 8'h3C, (s & 1) + 1, ak);
			chk(ak, 8'h07);
			poll();
			chk(32'(wq.size()), 0);
			if (s < 3) begin
				wr({4'h0, bnd[s] - 12'h001}, 8'h5A, 1, ak);
				chk(ak, 8'h0F);
				poll();
				chk(32'(wq.size()), 1);
			end
		end
	endtask
	task automatic s_lock();
		logic [7:0] ak;
		wr(16'h8000, 8'h00, 2, ak);
		poll();
		chk(wp_rd_data_o, 8'h0E);
		wr(16'hFFFF, 8'h03, 1, ak);
		poll();
		chk(wp_rd_data_o, 8'h03);
		wr(16'h8000, 8'h08, 1, ak);
		poll();
		chk(wp_rd_data_o, 8'h03);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		n_fail = 0;
		n_tests = 0;
		rst_n_i = 1'b0;
		#1;
		mst.start();
		mst.pulses(3);
		mst.stop();
		repeat (20) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		chk(busy_o, 1'b0);
		chk(wp_rd_data_o, 8'h00);
		mst.pulses(3);
		s_byte();
		s_select();
		s_page();
		s_protect();
		s_lock();
		results();
	end
	initial begin
		#300000;
		n_fail++;
		results();
	end
endmodule // testbench
`default_nettype wire
